// >>> idt_decode.sv
/*
   Instruction decode and timing top: takes one word per instruction, registers its fields,
   counts its instruction cycles and strobes the file read-modify-write.
   Assumes program memory holds the next word stable in the Q1 phase that starts each instruction, and the datapath
   gives the top bit of both file select pointers on the same clock.
*/
// Summary of operation
// RULE1 - each instruction arrives as one 14-bit word holding opcode and operands
// RULE2 - opcodes are sorted into byte, bit and literal-and-control groups
// RULE3 - one instruction cycle by default; calls and computed calls take two
// RULE4 - subroutine return, literal return and interrupt return take two cycles
// RULE5 - jumps, branches, bit-test skips and count skips take two cycles
// RULE6 - indirect access while its pointer addresses program memory adds one cycle
// RULE7 - every instruction cycle is four core clocks
// RULE8 - named file registers are read, modified, then stored; read happens always
// RULE9 - file address covers 0x00 to 0x7F
// RULE10 - destination bit 0 writes the working register, 1 the file register
// RULE11 - bit field picks one bit of the 8-bit file register
// RULE12 - pointer field picks one of two pointers and its indirect register
// RULE13 - don't-care word bits do not change the decoded operation
// RULE14 - literal widths 8, 11, 9, 7, 5 and 6 by word format
// RULE15 - byte words carry destination in bit 7, file address in bits 6..0
`timescale 1ns/1ps
module idt_decode #(
   parameter int INSTR_W = idt_pkg::INSTR_W,
   parameter int DATA_W = idt_pkg::DATA_W
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [INSTR_W-1:0] instr_word,
   input wire logic [1:0] fsr_msb,
   output logic [1:0] q_phase,
   output logic instr_taken,
   output idt_pkg::idt_class_t instr_class,
   output idt_pkg::idt_fmt_t instr_format,
   output logic [5:0] op_hi,
   output logic [idt_pkg::FILE_AW-1:0] file_addr,
   output logic dest_file,
   output logic [idt_pkg::BIT_W-1:0] bit_sel,
   output logic [DATA_W-1:0] bit_mask,
   output logic [idt_pkg::LIT_GEN_W-1:0] lit_gen,
   output logic [idt_pkg::LIT_JMP_W-1:0] lit_jmp,
   output logic [idt_pkg::LIT_BRA_W-1:0] lit_bra,
   output logic [idt_pkg::LIT_PAGE_W-1:0] lit_page,
   output logic [idt_pkg::LIT_BANK_W-1:0] lit_bank,
   output logic [idt_pkg::LIT_OFS_W-1:0] lit_ofs,
   output logic ptr_sel,
   output logic [1:0] inc_mode,
   output logic [1:0] cycles,
   output logic [1:0] cyc_index,
   output logic extra_cycle,
   output logic file_rd,
   output logic file_wr,
   output logic w_wr
);

   logic [1:0] phase;
   idt_pkg::idt_class_t d_cls;
   idt_pkg::idt_fmt_t d_fmt;
   logic d_two;
   logic d_acc;
   logic d_fwr;
   logic d_wwr;
   logic d_ptr;
   logic d_ind;
   logic start;
   logic last;

   logic fin_r, fin_nxt;
   logic taken_r, taken_nxt;
   idt_pkg::idt_class_t cls_r, cls_nxt;
   idt_pkg::idt_fmt_t fmt_r, fmt_nxt;
   logic [5:0] ophi_r, ophi_nxt;
   logic [6:0] faddr_r, faddr_nxt;
   logic dest_r, dest_nxt;
   logic [2:0] bsel_r, bsel_nxt;
   logic [DATA_W-1:0] bmask_r, bmask_nxt;
   logic [7:0] lgen_r, lgen_nxt;
   logic [10:0] ljmp_r, ljmp_nxt;
   logic [8:0] lbra_r, lbra_nxt;
   logic [6:0] lpage_r, lpage_nxt;
   logic [4:0] lbank_r, lbank_nxt;
   logic [5:0] lofs_r, lofs_nxt;
   logic ptr_r, ptr_nxt;
   logic [1:0] mode_r, mode_nxt;
   logic [1:0] cyc_r, cyc_nxt;
   logic [1:0] idx_r, idx_nxt;
   logic extra_r, extra_nxt;
   logic acc_r, acc_nxt;
   logic fwq_r, fwq_nxt;
   logic wwq_r, wwq_nxt;
   logic rd_r, rd_nxt;
   logic fwr_r, fwr_nxt;
   logic wwr_r, wwr_nxt;

   idt_qgen #(
      .PHASES(idt_pkg::PHASES)
   ) u_qgen (
      .core_clk(core_clk),
      .resetn(resetn),
      .phase(phase)
   );

   idt_field_dec u_dec (
      .word(instr_word),
      .fsr_msb(fsr_msb),
      .cls(d_cls),
      .fmt(d_fmt),
      .two_cyc(d_two),
      .file_acc(d_acc),
      .file_wr(d_fwr),
      .w_wr(d_wwr),
      .ptr_sel(d_ptr),
      .ind_extra(d_ind)
   );

   assign start = (phase == idt_pkg::PH_Q1) && fin_r;
   assign last = (idx_r == cyc_r - 2'h1);

   always_comb begin
      fin_nxt = fin_r;
      cls_nxt = cls_r;
      fmt_nxt = fmt_r;
      ophi_nxt = ophi_r;
      faddr_nxt = faddr_r;
      dest_nxt = dest_r;
      bsel_nxt = bsel_r;
      bmask_nxt = bmask_r;
      lgen_nxt = lgen_r;
      ljmp_nxt = ljmp_r;
      lbra_nxt = lbra_r;
      lpage_nxt = lpage_r;
      lbank_nxt = lbank_r;
      lofs_nxt = lofs_r;
      ptr_nxt = ptr_r;
      mode_nxt = mode_r;
      cyc_nxt = cyc_r;
      idx_nxt = idx_r;
      extra_nxt = extra_r;
      acc_nxt = acc_r;
      fwq_nxt = fwq_r;
      wwq_nxt = wwq_r;
      taken_nxt = start; // RULE1
      rd_nxt = start && d_acc; // RULE8
      if (start) begin
         fin_nxt = 1'b0;
         cls_nxt = d_cls; // RULE2
         fmt_nxt = d_fmt;
         ophi_nxt = instr_word[13:idt_pkg::OPHI_LO];
         faddr_nxt = d_acc ? instr_word[6:0] : idt_pkg::FILE_ADDR_MIN; // RULE9 RULE15
         dest_nxt = (d_cls == idt_pkg::CLS_BYTE) && instr_word[idt_pkg::D_POS]; // RULE15
         bsel_nxt = (d_cls == idt_pkg::CLS_BIT) ? instr_word[idt_pkg::BIT_LO +: idt_pkg::BIT_W] : 3'h0;
         bmask_nxt = (d_cls == idt_pkg::CLS_BIT) ? DATA_W'(1) << bsel_nxt : '0; // RULE11
         lgen_nxt = (d_fmt == idt_pkg::FMT_GEN) ? instr_word[7:0] : 8'h00; // RULE14
         ljmp_nxt = (d_fmt == idt_pkg::FMT_JMP) ? instr_word[10:0] : 11'h000; // RULE14
         lbra_nxt = (d_fmt == idt_pkg::FMT_BRA) ? instr_word[8:0] : 9'h000; // RULE14
         lpage_nxt = (d_fmt == idt_pkg::FMT_PAGE) ? instr_word[6:0] : 7'h00; // RULE14
         lbank_nxt = (d_fmt == idt_pkg::FMT_BANK) ? instr_word[4:0] : 5'h00; // RULE14
         lofs_nxt = (d_fmt == idt_pkg::FMT_OFS) ? instr_word[5:0] : 6'h00; // RULE14
         ptr_nxt = d_ptr; // RULE12
         mode_nxt = (d_fmt == idt_pkg::FMT_INC) ? instr_word[1:0] : 2'h0;
         cyc_nxt = idt_pkg::CYC_ONE + {1'b0, d_two} + {1'b0, d_ind}; // RULE3 RULE4 RULE5 RULE6
         idx_nxt = 2'h0;
         extra_nxt = 1'b0;
         acc_nxt = d_acc;
         fwq_nxt = d_fwr;
         wwq_nxt = d_wwr;
      end else if (phase == idt_pkg::PH_Q4 && !fin_r) begin
         if (last) begin
            fin_nxt = 1'b1; // RULE7
         end else begin
            idx_nxt = idx_r + 2'h1;
            extra_nxt = 1'b1;
         end
      end
      // store lands in Q4 of the final cycle, after the Q2 read
      fwr_nxt = (phase == idt_pkg::PH_Q3) && !fin_r && last && fwq_r; // RULE8 RULE10
      wwr_nxt = (phase == idt_pkg::PH_Q3) && !fin_r && last && wwq_r; // RULE10
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         fin_r <= 1'b1;
         taken_r <= 1'b0;
         cls_r <= idt_pkg::CLS_LIT;
         fmt_r <= idt_pkg::FMT_NONE;
         ophi_r <= 6'h00;
         faddr_r <= idt_pkg::FILE_ADDR_MIN;
         dest_r <= 1'b0;
         bsel_r <= 3'h0;
         bmask_r <= '0;
         lgen_r <= 8'h00;
         ljmp_r <= 11'h000;
         lbra_r <= 9'h000;
         lpage_r <= 7'h00;
         lbank_r <= 5'h00;
         lofs_r <= 6'h00;
         ptr_r <= 1'b0;
         mode_r <= 2'h0;
         cyc_r <= 2'h0;
         idx_r <= 2'h0;
         extra_r <= 1'b0;
         acc_r <= 1'b0;
         fwq_r <= 1'b0;
         wwq_r <= 1'b0;
         rd_r <= 1'b0;
         fwr_r <= 1'b0;
         wwr_r <= 1'b0;
      end else begin
         fin_r <= fin_nxt;
         taken_r <= taken_nxt;
         cls_r <= cls_nxt;
         fmt_r <= fmt_nxt;
         ophi_r <= ophi_nxt;
         faddr_r <= faddr_nxt;
         dest_r <= dest_nxt;
         bsel_r <= bsel_nxt;
         bmask_r <= bmask_nxt;
         lgen_r <= lgen_nxt;
         ljmp_r <= ljmp_nxt;
         lbra_r <= lbra_nxt;
         lpage_r <= lpage_nxt;
         lbank_r <= lbank_nxt;
         lofs_r <= lofs_nxt;
         ptr_r <= ptr_nxt;
         mode_r <= mode_nxt;
         cyc_r <= cyc_nxt;
         idx_r <= idx_nxt;
         extra_r <= extra_nxt;
         acc_r <= acc_nxt;
         fwq_r <= fwq_nxt;
         wwq_r <= wwq_nxt;
         rd_r <= rd_nxt;
         fwr_r <= fwr_nxt;
         wwr_r <= wwr_nxt;
      end
   end

   assign q_phase = phase;
   assign instr_taken = taken_r;
   assign instr_class = cls_r;
   assign instr_format = fmt_r;
   assign op_hi = ophi_r;
   assign file_addr = faddr_r;
   assign dest_file = dest_r;
   assign bit_sel = bsel_r;
   assign bit_mask = bmask_r;
   assign lit_gen = lgen_r;
   assign lit_jmp = ljmp_r;
   assign lit_bra = lbra_r;
   assign lit_page = lpage_r;
   assign lit_bank = lbank_r;
   assign lit_ofs = lofs_r;
   assign ptr_sel = ptr_r;
   assign inc_mode = mode_r;
   assign cycles = cyc_r;
   assign cyc_index = idx_r;
   assign extra_cycle = extra_r;
   assign file_rd = rd_r;
   assign file_wr = fwr_r;
   assign w_wr = wwr_r;

   // helper: clocks since the last instruction start
   logic [3:0] gap_r;
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         gap_r <= 4'h0;
      end else if (start) begin
         gap_r <= 4'h1;
      end else begin
         gap_r <= gap_r + 4'h1;
      end
   end

   sequence s_take_rmw;
      taken_r && acc_r && fwq_r && (cyc_r == 2'h1);
   endsequence

   sequence s_read_then_store;
      rd_r ##1 !fwr_r ##1 fwr_r;
   endsequence

   qcycle_len_a: assert property (@(posedge core_clk) disable iff (!resetn) // RULE7
      taken_r |=> (!taken_r) [*3])
      else $error("instruction taken again inside four clocks");

   instr_span_a: assert property (@(posedge core_clk) disable iff (!resetn) // RULE3
      start && (cyc_r != 2'h0) |-> gap_r == {cyc_r, 2'b00})
      else $error("instruction span differs from four clocks per cycle");

   two_cycle_a: assert property (@(posedge core_clk) disable iff (!resetn) // RULE5
      start && d_two && !d_ind |=> cyc_r == idt_pkg::CYC_TWO)
      else $error("two-cycle instruction not charged two cycles");

   ind_extra_a: assert property (@(posedge core_clk) disable iff (!resetn) // RULE6
      start && d_ind |=> cyc_r == ($past(d_two) ? idt_pkg::CYC_THREE : idt_pkg::CYC_TWO))
      else $error("indirect access to program memory missed its extra cycle");

   rmw_order_a: assert property (@(posedge core_clk) disable iff (!resetn) // RULE8
      s_take_rmw |-> s_read_then_store)
      else $error("file store not preceded by its read");

   rmw_read_a: assert property (@(posedge core_clk) disable iff (!resetn) // RULE8
      taken_r |-> rd_r == acc_r)
      else $error("file register not read by a file instruction");

   dest_sel_a: assert property (@(posedge core_clk) disable iff (!resetn) // RULE10
      (fwr_r && cls_r == idt_pkg::CLS_BYTE |-> dest_r) and (wwr_r |-> !dest_r))
      else $error("result routed against destination bit");

   bit_mask_a: assert property (@(posedge core_clk) disable iff (!resetn) // RULE11
      taken_r && cls_r == idt_pkg::CLS_BIT |-> $onehot(bmask_r) && bmask_r[bsel_r])
      else $error("bit mask does not select the bit field");

   byte_fields_a: assert property (@(posedge core_clk) disable iff (!resetn) // RULE15
      taken_r && acc_r && cls_r == idt_pkg::CLS_BYTE |-> faddr_r == $past(instr_word[6:0])
         && dest_r == $past(instr_word[idt_pkg::D_POS]))
      else $error("byte word fields misplaced");

   ptr_pick_a: assert property (@(posedge core_clk) disable iff (!resetn) // RULE12
      start && instr_word[13:8] == 6'b11_1111 |=> ptr_r == $past(instr_word[idt_pkg::PTR_OFS_POS]))
      else $error("pointer select not taken from the word");

   clr_w_a: assert property (@(posedge core_clk) disable iff (!resetn) // RULE13
      start && idt_pkg::idt_match(instr_word, idt_pkg::CLRW_PAT, idt_pkg::CLRW_MSK) |=> !acc_r && wwq_r)
      else $error("don't-care bits changed the clear-working decode");

endmodule : idt_decode

// >>> idt_field_dec.sv
/*
   Combinational classifier for one 14-bit instruction word.
   Assumes the pointer top bits come from the datapath on the same clock.
*/
`timescale 1ns/1ps
module idt_field_dec (
   input wire logic [13:0] word,
   input wire logic [1:0] fsr_msb,
   output idt_pkg::idt_class_t cls,
   output idt_pkg::idt_fmt_t fmt,
   output logic two_cyc,
   output logic file_acc,
   output logic file_wr,
   output logic w_wr,
   output logic ptr_sel,
   output logic ind_extra
);

   logic d_bit;

   always_comb begin
      d_bit = word[idt_pkg::D_POS];
      cls = idt_pkg::CLS_LIT;
      fmt = idt_pkg::FMT_GEN;
      two_cyc = 1'b0;
      file_acc = 1'b0;
      file_wr = 1'b0;
      w_wr = 1'b0;
      ptr_sel = 1'b0;
      casez (word[13:8])
         6'b00_0000: begin
            if (d_bit) begin
               cls = idt_pkg::CLS_BYTE;
               fmt = idt_pkg::FMT_BYTE;
               file_acc = 1'b1;
               file_wr = 1'b1;
            end else if (idt_pkg::idt_match(word, idt_pkg::BANK_PAT, idt_pkg::BANK_MSK)) begin
               fmt = idt_pkg::FMT_BANK;
            end else if (idt_pkg::idt_match(word, idt_pkg::INC_PAT, idt_pkg::INC_MSK)) begin
               fmt = idt_pkg::FMT_INC;
               ptr_sel = word[idt_pkg::PTR_INC_POS]; // RULE12
            end else begin
               fmt = idt_pkg::FMT_NONE;
               two_cyc = idt_pkg::idt_match(word, idt_pkg::RET_PAT, idt_pkg::FULL_MSK)
                  | idt_pkg::idt_match(word, idt_pkg::RETIRQ_PAT, idt_pkg::FULL_MSK)
                  | idt_pkg::idt_match(word, idt_pkg::COMPUTED_SUBROUTINE_CALL_PAT, idt_pkg::FULL_MSK)
                  | idt_pkg::idt_match(word, idt_pkg::BRW_PAT, idt_pkg::FULL_MSK); // RULE3 RULE4 RULE5
            end
         end
         6'b00_????, 6'b11_0101, 6'b11_0110, 6'b11_0111, 6'b11_1011, 6'b11_1101: begin
            cls = idt_pkg::CLS_BYTE; // RULE2
            fmt = idt_pkg::FMT_BYTE;
            if (idt_pkg::idt_match(word, idt_pkg::CLRW_PAT, idt_pkg::CLRW_MSK)) begin
               w_wr = 1'b1; // RULE13
            end else begin
               file_acc = 1'b1;
               file_wr = d_bit; // RULE10
               w_wr = !d_bit; // RULE10
               two_cyc = (word[13:8] == 6'b00_1011) || (word[13:8] == 6'b00_1111); // RULE5
            end
         end
         6'b01_????: begin
            cls = idt_pkg::CLS_BIT; // RULE2
            fmt = idt_pkg::FMT_BIT;
            file_acc = 1'b1;
            file_wr = !word[11];
            two_cyc = word[11]; // RULE5
         end
         6'b10_????: begin
            fmt = idt_pkg::FMT_JMP;
            two_cyc = 1'b1; // RULE3 RULE5
         end
         6'b11_0001: begin
            fmt = d_bit ? idt_pkg::FMT_PAGE : idt_pkg::FMT_OFS;
            ptr_sel = word[idt_pkg::PTR_OFS_POS]; // RULE12
         end
         6'b11_001?: begin
            fmt = idt_pkg::FMT_BRA;
            two_cyc = 1'b1; // RULE5
         end
         6'b11_0100: begin
            two_cyc = 1'b1; // RULE4
         end
         6'b11_1111: begin
            fmt = idt_pkg::FMT_OFS;
            ptr_sel = word[idt_pkg::PTR_OFS_POS]; // RULE12
         end
         default: begin
            fmt = idt_pkg::FMT_GEN;
         end
      endcase
      if (file_acc) begin
         ptr_sel = word[0];
      end
      ind_extra = (file_acc && (word[6:1] == idt_pkg::IND_ADDR_HI) && fsr_msb[word[0]])
         || (fmt == idt_pkg::FMT_INC && fsr_msb[ptr_sel])
         || (word[13:8] == 6'b11_1111 && fsr_msb[ptr_sel]); // RULE6
   end

endmodule : idt_field_dec

// >>> idt_pkg.sv
/*
   Shared constants, types and the opcode match function for the instruction decode and timing block.
   Assumes 14-bit instruction words and a four-phase instruction cycle.
*/
package idt_pkg;

   localparam int INSTR_W = 14;
   localparam int DATA_W = 8;
   localparam int PHASES = 4;
   localparam int FILE_AW = 7;
   localparam int BIT_W = 3;

   // literal widths per word format
   localparam int LIT_GEN_W = 8;
   localparam int LIT_JMP_W = 11;
   localparam int LIT_BRA_W = 9;
   localparam int LIT_PAGE_W = 7;
   localparam int LIT_BANK_W = 5;
   localparam int LIT_OFS_W = 6;

   // field positions
   localparam int D_POS = 7;
   localparam int BIT_LO = 7;
   localparam int PTR_OFS_POS = 6;
   localparam int PTR_INC_POS = 2;
   localparam int OPHI_LO = 8;

   localparam logic [6:0] FILE_ADDR_MIN = 7'h00;
   localparam logic [6:0] FILE_ADDR_MAX = 7'h7f;
   localparam logic [5:0] IND_ADDR_HI = 6'h00;

   localparam logic [1:0] PH_Q1 = 2'h0;
   localparam logic [1:0] PH_Q3 = 2'h2;
   localparam logic [1:0] PH_Q4 = 2'h3;
   localparam logic [1:0] CYC_ONE = 2'h1;
   localparam logic [1:0] CYC_TWO = 2'h2;
   localparam logic [1:0] CYC_THREE = 2'h3;

   // whole-word patterns and masks; cleared mask bits are don't-care
   localparam logic [13:0] CLRW_PAT = 14'h0100;
   localparam logic [13:0] CLRW_MSK = 14'h3ffc;
   localparam logic [13:0] RET_PAT = 14'h0008;
   localparam logic [13:0] RETIRQ_PAT = 14'h0009;
   localparam logic [13:0] COMPUTED_SUBROUTINE_CALL_PAT = 14'h000a;
   localparam logic [13:0] BRW_PAT = 14'h000b;
   localparam logic [13:0] FULL_MSK = 14'h3fff;
   localparam logic [13:0] BANK_PAT = 14'h0020;
   localparam logic [13:0] BANK_MSK = 14'h3fe0;
   localparam logic [13:0] INC_PAT = 14'h0010;
   localparam logic [13:0] INC_MSK = 14'h3ff8;

   typedef enum logic [1:0] {
      CLS_BYTE = 2'b00,
      CLS_BIT = 2'b01,
      CLS_LIT = 2'b10
   } idt_class_t;

   typedef enum logic [3:0] {
      FMT_NONE = 4'b0000,
      FMT_BYTE = 4'b0001,
      FMT_BIT = 4'b0010,
      FMT_GEN = 4'b0011,
      FMT_JMP = 4'b0100,
      FMT_BRA = 4'b0101,
      FMT_PAGE = 4'b0110,
      FMT_BANK = 4'b0111,
      FMT_OFS = 4'b1000,
      FMT_INC = 4'b1001
   } idt_fmt_t;

   function automatic logic idt_match(input logic [13:0] w, input logic [13:0] pat, input logic [13:0] msk);
      idt_match = ((w ^ pat) & msk) == 14'h0000;
   endfunction : idt_match

endpackage : idt_pkg

// >>> idt_pmem.sv
/*
   Program memory stand-in: shows one queued word, with its pointer top bits, in the capture phase only.
   Assumes the decoder's phase, taken pulse and cycle count; outside capture it shows the inverse.
*/
`timescale 1ns/1ps
module idt_pmem (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [1:0] q_phase,
   input wire logic instr_taken,
   input wire logic [1:0] cycles,
   output logic [13:0] instr_word,
   output logic [1:0] fsr_msb
);
   logic [15:0] q[$];
   logic [15:0] pend;
   logic pq;
   int skip;

   task automatic load(input logic [15:0] e);
      q.push_back(e);
   endtask : load

   initial begin
      pend = 16'h0000;
      pq = 1'b0;
      skip = 0;
      {fsr_msb, instr_word} = 16'h0000;
   end

   always @(negedge core_clk) begin
      if (!resetn) begin
         skip = 0;
      end else if (instr_taken === 1'b1) begin
         skip = int'(cycles) - 1;
         if (pq) begin
            void'(q.pop_front());
         end
         pq = 1'b0;
      end
      if (q_phase == 2'h0 && skip == 0) begin
         pq = (q.size() > 0);
         pend = pq ? q[0] : 16'h0000;
         {fsr_msb, instr_word} = pend;
      end else begin
         if (q_phase == 2'h0) begin
            skip = skip - 1;
         end
         // word only valid in the capture clock
         {fsr_msb, instr_word} = ~pend;
      end
   end
endmodule : idt_pmem

// >>> idt_qgen.sv
/*
   Phase counter that splits each instruction cycle into four core clocks.
   Assumes a free-running core clock and asynchronous active-low reset.
*/
`timescale 1ns/1ps
module idt_qgen #(
   parameter int PHASES = idt_pkg::PHASES
) (
   input wire logic core_clk,
   input wire logic resetn,
   output logic [1:0] phase
);

   logic [1:0] phase_r;
   logic [1:0] phase_nxt;

   always_comb begin
      if (phase_r == 2'(PHASES - 1)) begin
         phase_nxt = 2'h0;
      end else begin
         phase_nxt = phase_r + 2'h1;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         phase_r <= 2'h0;
      end else begin
         phase_r <= phase_nxt;
      end
   end

   assign phase = phase_r;

endmodule : idt_qgen

// >>> tb.sv
/*
   Self-checking bench for the decode and timing top, fed by a program memory stand-in.
   Assumes one capture every 4*cycles clocks and strobes as in the hand-over timing.
*/
`timescale 1ns/1ps
module tb;
   logic core_clk, resetn, instr_taken, dest_file, ptr_sel, extra_cycle, file_rd, file_wr, w_wr;
   logic [13:0] instr_word, w;
   logic [1:0] fsr_msb, q_phase, inc_mode, cycles, cyc_index;
   idt_pkg::idt_class_t instr_class;
   idt_pkg::idt_fmt_t instr_format;
   logic [5:0] op_hi, lit_ofs;
   logic [6:0] file_addr, lit_page;
   logic [2:0] bit_sel;
   logic [7:0] bit_mask, lit_gen;
   logic [10:0] lit_jmp;
   logic [8:0] lit_bra;
   logic [4:0] lit_bank;
   int num_errors = 0;
   int tests_run = 0;
   int k, pc, i, j, x_cyc;
   logic live, x_rd, x_fw, x_ww, x_cf, x_cs, have_ref;
   logic [79:0] x_vec, ref_fld;
   wire [79:0] fld = {instr_class, instr_format, op_hi, file_addr, dest_file, bit_sel, bit_mask, lit_gen,
      lit_jmp, lit_bra, lit_page, lit_bank, lit_ofs, ptr_sel, inc_mode};

   idt_pmem idt_pmem_inst (.core_clk(core_clk), .resetn(resetn), .q_phase(q_phase), .instr_taken(instr_taken),
      .cycles(cycles), .instr_word(instr_word), .fsr_msb(fsr_msb));
   idt_decode idt_decode_inst (.core_clk(core_clk), .resetn(resetn), .instr_word(instr_word), .fsr_msb(fsr_msb),
      .q_phase(q_phase), .instr_taken(instr_taken), .instr_class(instr_class), .instr_format(instr_format),
      .op_hi(op_hi), .file_addr(file_addr), .dest_file(dest_file), .bit_sel(bit_sel), .bit_mask(bit_mask),
      .lit_gen(lit_gen), .lit_jmp(lit_jmp), .lit_bra(lit_bra), .lit_page(lit_page), .lit_bank(lit_bank),
      .lit_ofs(lit_ofs), .ptr_sel(ptr_sel), .inc_mode(inc_mode), .cycles(cycles), .cyc_index(cyc_index),
      .extra_cycle(extra_cycle), .file_rd(file_rd), .file_wr(file_wr), .w_wr(w_wr));

   initial core_clk = 1'b0;
   always #50 core_clk = ~core_clk;

   task automatic check(input logic [95:0] seen, input logic [95:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic conclude;
      $display("counts: %0d compares, %0d mismatches", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : conclude

   // reference decode of one queued entry {pointer bits, word}
   task automatic model(input logic [15:0] en);
      logic [13:0] v;
      logic [1:0] cls;
      logic [3:0] fmt;
      logic [6:0] fa;
      logic [2:0] b;
      logic byt, fil, ps, dd, clrw;
      v = en[13:0];
      cls = 2'h2;
      fmt = 4'h0;
      fa = 7'h00;
      b = 3'h0;
      {byt, fil, ps, dd, clrw} = 5'h00;
      x_cyc = 1;
      x_cf = 1'b1;
      x_cs = 1'b1;
      casez (v)
         14'b00_000?_1???_????, 14'b11_0101_????_????, 14'b11_011?_????_????, 14'b11_1011_????_????,
         14'b11_1101_????_????: byt = 1'b1;
         14'b00_0000_001?_????: fmt = 4'h7;
         14'b00_0000_0001_0???: begin
            fmt = 4'h9;
            ps = v[2];
            x_cs = 1'b0;
         end
         14'b00_0000_0000_10??: x_cyc = 2;
         14'b00_0001_0000_00??: begin
            clrw = 1'b1;
            x_cf = 1'b0;
         end
         14'b00_000?_0???_????: begin
            x_cf = 1'b0;
            x_cs = 1'b0;
         end
         14'b00_????_????_????: byt = 1'b1;
         14'b01_????_????_????: begin
            cls = 2'h1;
            fmt = 4'h2;
            fil = 1'b1;
            b = v[9:7];
            x_cyc = v[11] ? 2 : 1;
         end
         14'b10_????_????_????: begin
            fmt = 4'h4;
            x_cyc = 2;
         end
         14'b11_0001_1???_????: begin
            fmt = 4'h6;
            ps = v[6];
         end
         14'b11_0001_0???_????, 14'b11_1111_????_????: begin
            fmt = 4'h8;
            ps = v[6];
            x_cs = 1'b0;
         end
         14'b11_001?_????_????: begin
            fmt = 4'h5;
            x_cyc = 2;
         end
         14'b11_0100_????_????: begin
            fmt = 4'h3;
            x_cyc = 2;
         end
         default: fmt = 4'h3;
      endcase
      if (byt) begin
         cls = 2'h0;
         fmt = 4'h1;
         fil = 1'b1;
         dd = v[7];
         x_cyc = (v[13:8] == 6'h0b || v[13:8] == 6'h0f) ? 2 : 1;
      end
      if (fil) begin
         fa = v[6:0];
         ps = v[0];
         x_cyc = x_cyc + ((fa[6:1] == 6'h00 && en[14 + fa[0]]) ? 1 : 0);
      end
      // pointer moves through the indirect register, not add-to-pointer
      if (fmt == 4'h9 || v[13:8] == 6'h3f) x_cyc = x_cyc + (en[14 + ps] ? 1 : 0);
      x_rd = fil;
      x_fw = fil && (byt ? dd : !v[11]);
      x_ww = (byt && !dd) || clrw;
      x_vec = {cls, fmt, v[13:8], fa, dd, b, (cls == 2'h1) ? 8'h01 << b : 8'h00, (fmt == 4'h3) ? v[7:0] : 8'h00,
         (fmt == 4'h4) ? v[10:0] : 11'h000, (fmt == 4'h5) ? v[8:0] : 9'h000, (fmt == 4'h6) ? v[6:0] : 7'h00,
         (fmt == 4'h7) ? v[4:0] : 5'h00, (fmt == 4'h8) ? v[5:0] : 6'h00, ps, (fmt == 4'h9) ? v[1:0] : 2'h0};
   endtask : model

   always @(negedge core_clk) begin
      if (!resetn) begin
         live = 1'b0;
      end else begin
         k++;
         if (instr_taken === 1'b1) begin
            if (live) check(k, 4 * pc);
            model(idt_pmem_inst.pend);
            check(q_phase, 2'h1);
            check(cycles, x_cyc);
            if (x_cf) check(fld, x_vec);
            if (!x_cf && x_cs && have_ref) check(fld, ref_fld);
            if (!x_cf && x_cs) ref_fld = fld;
            have_ref = have_ref | (!x_cf && x_cs);
            pc = x_cyc;
            k = 0;
            live = 1'b1;
         end
         if (live && x_cs) begin
            check(file_rd, k == 0 && x_rd);
            check({file_wr, w_wr}, {k == 4 * pc - 2 && x_fw, k == 4 * pc - 2 && x_ww});
            if (k == 4 * pc - 2) check({extra_cycle, cyc_index}, {pc > 1, 2'(pc - 1)});
         end
      end
   end

   function automatic logic ok(input logic [13:0] v);
      ok = 1'b1;
      if (v[13:7] == 7'h00 && !(v[6:5] == 2'b01 || v[6:2] == 5'h02 || v[6:3] == 4'h2)) ok = 1'b0;
      if (v[13:7] == 7'h02 && v[6:2] != 5'h00) ok = 1'b0;
   endfunction : ok

   task automatic drain;
      int n;
      n = 0;
      while (idt_pmem_inst.q.size() > 0 && n < 6000) begin
         @(negedge core_clk);
         n++;
      end
      repeat (16) @(negedge core_clk);
   endtask : drain

   initial begin
      resetn = 1'b0;
      have_ref = 1'b0;
      live = 1'b0;
      k = 0;
      pc = 1;
      void'($urandom(65604));
      @(posedge core_clk);
      // every opcode group back to back, random operands and pointer bits
      for (i = 0; i < 320; i++) begin
         w = {6'(i % 64), 8'h00};
         j = 0;
         do begin
            w[7:0] = 8'($urandom);
            if ($urandom % 4 == 0) w[6:1] = 6'h00;
            j++;
         end while (!ok(w) && j < 60);
         if (ok(w)) idt_pmem_inst.load({2'($urandom), w});
      end
      repeat (4) @(negedge core_clk);
      resetn <= 1'b1;
      drain();
      $display("test opcode sweep done");
      @(posedge core_clk);
      for (i = 0; i < 4; i++) idt_pmem_inst.load({2'h0, 14'h0100 | 14'(i)});
      drain();
      $display("test dont care bits done");
      @(posedge core_clk);
      idt_pmem_inst.load(16'h4b81);
      idt_pmem_inst.load(16'h3a00);
      idt_pmem_inst.load(16'h0080);
      repeat (6) @(negedge core_clk);
      resetn <= 1'b0;
      @(negedge core_clk);
      check({fld, q_phase, cycles, instr_taken, file_rd, file_wr, w_wr}, {2'h2, 78'h0, 8'h00});
      repeat (3) @(negedge core_clk);
      resetn <= 1'b1;
      drain();
      $display("test mid run reset done");
      conclude();
   end

   initial begin
      #3000000;
      num_errors++;
      $display("watchdog expired");
      conclude();
   end
endmodule : tb
